// ==== smcr_pkg.sv ====
// Package for the misc configuration register slice: offsets, fields, resets.
// Assumes a 16-bit register port with one-cycle strobes on a single clock.
package smcr_pkg;
  // ==========================================================================
  // Register offsets (word index on the register port)
  localparam logic [3:0] SMCR_ADDR_MASK_STATE = 4'h0;
  localparam logic [3:0] SMCR_ADDR_SCRATCH_A = 4'h1;
  localparam logic [3:0] SMCR_ADDR_SCRATCH_B = 4'h2;
  localparam logic [3:0] SMCR_ADDR_WAKE_ID = 4'h3;
  localparam logic [3:0] SMCR_ADDR_EVENTS = 4'h4;
  localparam int SMCR_ADDR_W = 4;
  localparam int SMCR_DATA_W = 16;
  // ==========================================================================
  // Field positions
  localparam int SMCR_BIT_THERMAL = 0;
  localparam int SMCR_BIT_TXTO = 1;
  localparam int SMCR_STATE_LSB = 2;
  localparam int SMCR_STATE_W = 3;
  localparam int SMCR_REQ_W = 8;
  localparam int SMCR_CFG_LSB = 8;
  localparam int SMCR_CFG_W = 7;
  // ==========================================================================
  // Reset values and masks
  localparam logic [15:0] SMCR_RESET_WORD = 16'h0000;
  localparam logic [1:0] SMCR_RESET_PAIR = 2'h0;
  localparam logic [7:0] SMCR_RESET_REQ = 8'h00;
  localparam logic [6:0] SMCR_RESET_CFG = 7'h00;
  localparam logic [2:0] SMCR_RESET_STATE = 3'h0;
  // ==========================================================================
  // Transceiver state codes
  typedef enum logic [2:0] {
    SMCR_XS_OFF = 3'b000,
    SMCR_XS_WAKE_CAPABLE = 3'b001,
    SMCR_XS_INVALID_2 = 3'b010,
    SMCR_XS_OFF_ALT = 3'b011,
    SMCR_XS_INVALID_4 = 3'b100,
    SMCR_XS_LISTEN_ONLY = 3'b101,
    SMCR_XS_INVALID_6 = 3'b110,
    SMCR_XS_ACTIVE = 3'b111
  } smcr_xcvr_state_t;
endpackage

// ==== smcr_sync2.sv ====
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes inputs come from outside the clock domain.
`timescale 1ns/10ps
module smcr_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } smcr_sync_state_t;
  smcr_sync_state_t state_reg;
  smcr_sync_state_t state_next;

  // ==========================================================================
  // First stage feeds only the second
  always_comb
  begin
    state_next = state_reg;
    state_next.meta = async_i;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.stable;
endmodule // smcr_sync2

// ==== smcr_misc_regs.sv ====
// Misc configuration register slice of the basis chip: transceiver mask and
// state, two scratch words, wake-pin identification configuration, events.
// Assumes transceiver status levels arrive asynchronously from analog logic.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module smcr_misc_regs
  import smcr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [SMCR_ADDR_W-1:0] reg_addr_i,
  input wire logic [SMCR_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [SMCR_DATA_W-1:0] reg_rdata_o,
  input wire logic thermal_shutdown_i,
  input wire logic tx_timeout_i,
  input wire logic [SMCR_STATE_W-1:0] transceiver_state_i,
  output logic irq_o,
  output logic [3:0] pin3_pull_req_o,
  output logic [3:0] pin2_pull_req_o,
  output logic pin3_ident_select_o,
  output logic pin2_ident_select_o,
  output logic pin3_high_current_o,
  output logic pin2_high_current_o,
  output logic pin3_threshold_select_o,
  output logic pin2_threshold_select_o,
  output logic failsafe_threshold_select_o
);
  // ==========================================================================
  // Reset release
  logic [1:0] rst_pipe_reg;
  logic rst_n;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_pipe_reg <= 2'h0;
    end
    else
    begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe_reg[1];

  // ==========================================================================
  // Status synchronisers: analog levels cross into the clock domain
  logic [4:0] status_sync;

  smcr_sync2 #(
    .WIDTH(5)
  ) u_status_sync (
    .clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .async_i({transceiver_state_i, tx_timeout_i, thermal_shutdown_i}),
    .sync_o(status_sync)
  );

  // ==========================================================================
  // State of the slice
  typedef struct packed {
    logic [1:0] irq_mask;
    logic [SMCR_STATE_W-1:0] xcvr_state;
    logic [1:0] events;
    logic [1:0] status_prev;
    logic [SMCR_DATA_W-1:0] scratch_a;
    logic [SMCR_DATA_W-1:0] scratch_b;
    logic [SMCR_CFG_W-1:0] cfg;
    logic [SMCR_REQ_W-1:0] pull_req;
    logic [SMCR_DATA_W-1:0] rdata;
    logic irq;
  } smcr_state_t;

  smcr_state_t state_reg;
  smcr_state_t state_next;

  logic [1:0] status_now;
  logic [1:0] status_rise;
  logic [1:0] wr_clear;
  logic [SMCR_DATA_W-1:0] read_word;

  assign status_now = status_sync[1:0];
  assign status_rise = status_now & ~state_reg.status_prev;

  // ==========================================================================
  // Write-one-to-clear strobes for the event flags
  always_comb
  begin
    wr_clear = 2'h0;
    if (reg_wr_i && (reg_addr_i == SMCR_ADDR_EVENTS))
    begin
      wr_clear = reg_wdata_i[1:0];
    end
  end

  // ==========================================================================
  // Read multiplexer; unmapped addresses read zero
  always_comb
  begin
    read_word = SMCR_RESET_WORD;
    unique case (reg_addr_i)
      SMCR_ADDR_MASK_STATE:
      begin
        read_word[SMCR_BIT_THERMAL] = state_reg.irq_mask[0];
        read_word[SMCR_BIT_TXTO] = state_reg.irq_mask[1];
        read_word[SMCR_STATE_LSB +: SMCR_STATE_W] = state_reg.xcvr_state;
      end
      SMCR_ADDR_SCRATCH_A:
      begin
        read_word = state_reg.scratch_a;
      end
      SMCR_ADDR_SCRATCH_B:
      begin
        read_word = state_reg.scratch_b;
      end
      SMCR_ADDR_WAKE_ID:
      begin
        // Request strobes are write-only and read back as zero
        read_word[SMCR_CFG_LSB +: SMCR_CFG_W] = state_reg.cfg;
      end
      SMCR_ADDR_EVENTS:
      begin
        read_word[1:0] = state_reg.events;
      end
      default:
      begin
        read_word = SMCR_RESET_WORD;
      end
    endcase
  end

  // ==========================================================================
  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    state_next.status_prev = status_now;
    state_next.xcvr_state = status_sync[4:2];
    state_next.pull_req = SMCR_RESET_REQ;
    // Events latch on rising status; a new event wins over a clear
    state_next.events = (state_reg.events & ~wr_clear) | status_rise;
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        SMCR_ADDR_MASK_STATE:
        begin
          state_next.irq_mask = reg_wdata_i[1:0];
        end
        SMCR_ADDR_SCRATCH_A:
        begin
          state_next.scratch_a = reg_wdata_i;
        end
        SMCR_ADDR_SCRATCH_B:
        begin
          state_next.scratch_b = reg_wdata_i;
        end
        SMCR_ADDR_WAKE_ID:
        begin
          // One-cycle pulses; a zero bit leaves the resistor alone
          state_next.pull_req = reg_wdata_i[SMCR_REQ_W-1:0];
          state_next.cfg = reg_wdata_i[SMCR_CFG_LSB +: SMCR_CFG_W];
        end
        default:
        begin
          state_next.irq_mask = state_reg.irq_mask;
        end
      endcase
    end
    state_next.rdata = reg_rd_i ? read_word : SMCR_RESET_WORD;
    // Mask bit 1 inhibits; computed from next flags so irq tracks them
    state_next.irq = |(state_next.events & ~state_next.irq_mask);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs straight from flops
  assign reg_rdata_o = state_reg.rdata;
  assign irq_o = state_reg.irq;
  assign pin3_pull_req_o = state_reg.pull_req[3:0];
  assign pin2_pull_req_o = state_reg.pull_req[7:4];
  assign pin3_ident_select_o = state_reg.cfg[0];
  assign pin2_ident_select_o = state_reg.cfg[1];
  assign pin3_high_current_o = state_reg.cfg[2];
  assign pin2_high_current_o = state_reg.cfg[3];
  assign pin3_threshold_select_o = state_reg.cfg[4];
  assign pin2_threshold_select_o = state_reg.cfg[5];
  assign failsafe_threshold_select_o = state_reg.cfg[6];
endmodule // smcr_misc_regs

// ==== smcr_misc_regs_props.sv ====
// Checker for the misc register slice, watching its ports only.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module smcr_misc_regs_props
  import smcr_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic thermal_shutdown_i,
  input wire logic tx_timeout_i,
  input wire logic [2:0] transceiver_state_i,
  input wire logic irq_o,
  input wire logic [3:0] pin3_pull_req_o,
  input wire logic [3:0] pin2_pull_req_o,
  input wire logic pin3_ident_select_o,
  input wire logic pin2_ident_select_o,
  input wire logic pin3_high_current_o,
  input wire logic pin2_high_current_o,
  input wire logic pin3_threshold_select_o,
  input wire logic pin2_threshold_select_o,
  input wire logic failsafe_threshold_select_o
);
  // ==========================================================
  // Decoded strobes and the config bits in register order
  wire wr_id = reg_wr_i && reg_addr_i == SMCR_ADDR_WAKE_ID;
  wire rd_id = reg_rd_i && reg_addr_i == SMCR_ADDR_WAKE_ID;
  wire wr_m3 = reg_wr_i && reg_addr_i == SMCR_ADDR_MASK_STATE && reg_wdata_i[1:0] == 2'h3;
  wire [6:0] cfg = {failsafe_threshold_select_o, pin2_threshold_select_o,
    pin3_threshold_select_o, pin2_high_current_o, pin3_high_current_o,
    pin2_ident_select_o, pin3_ident_select_o};
  wire [7:0] req = {pin2_pull_req_o, pin3_pull_req_o};
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // Register port relations
  a_id_cfg_load: assert property (wr_id |=> cfg == $past(reg_wdata_i[14:8]))
    else $error("id config not loaded");
  a_id_cfg_hold: assert property (!wr_id |=> $stable(cfg))
    else $error("id config moved");
  a_pull_req_pulse: assert property (wr_id |=> req == $past(reg_wdata_i[7:0]))
    else $error("pull request missing");
  a_pull_req_idle: assert property (!wr_id |=> req == 8'h00)
    else $error("pull request not one cycle");
  a_id_read_zero: assert property (rd_id |=> reg_rdata_o[15] == 1'b0 && reg_rdata_o[7:0] == 8'h00)
    else $error("request bits read back");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data outside slot");
  a_unmapped_read: assert property (reg_rd_i && reg_addr_i > SMCR_ADDR_EVENTS |=> reg_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_mask_all_irq: assert property (wr_m3 |=> ##1 !irq_o)
    else $error("masked interrupt raised");
endmodule // smcr_misc_regs_props

bind smcr_misc_regs smcr_misc_regs_props i_smcr_misc_regs_props (.sys_clk_i, .rst_n_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .thermal_shutdown_i,
  .tx_timeout_i, .transceiver_state_i, .irq_o, .pin3_pull_req_o, .pin2_pull_req_o,
  .pin3_ident_select_o, .pin2_ident_select_o, .pin3_high_current_o, .pin2_high_current_o,
  .pin3_threshold_select_o, .pin2_threshold_select_o, .failsafe_threshold_select_o);

// ==== tb_smcr_misc_regs.sv ====
// Self-checking bench for the misc register slice.
// Assumes the bench drives every port; status levels step slowly.
`timescale 1ns/10ps
module tb_smcr_misc_regs
  import smcr_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [1:0] st = 2'h0;
  logic [2:0] xs = 3'h0;
  logic [15:0] rdata, v;
  logic [3:0] p3, p2;
  logic [6:0] cfg;
  logic irq;
  int err_total = 0;
  int n_compared = 0;
  // ==========================================================
  // Clock, device and bus tasks
  always #4 sys_clk = ~sys_clk;
  smcr_misc_regs i_smcr_misc_regs (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .thermal_shutdown_i(st[0]), .tx_timeout_i(st[1]), .transceiver_state_i(xs),
    .irq_o(irq), .pin3_pull_req_o(p3), .pin2_pull_req_o(p2), .pin3_ident_select_o(cfg[0]),
    .pin2_ident_select_o(cfg[1]), .pin3_high_current_o(cfg[2]), .pin2_high_current_o(cfg[3]),
    .pin3_threshold_select_o(cfg[4]), .pin2_threshold_select_o(cfg[5]),
    .failsafe_threshold_select_o(cfg[6]));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog: the tests need well under 2000 cycles
  initial
  begin
    #100000;
    err_total++;
    complete_run;
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(11));
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int a = 0; a < 5; a++) rd_chk("reset", a[3:0], 16'h0000);
    $display("reset values done");
    repeat (6)
    begin
      v = 16'($urandom);
      wr_reg(SMCR_ADDR_SCRATCH_A, v);
      wr_reg(SMCR_ADDR_SCRATCH_B, ~v);
      rd_chk("scratch_a", SMCR_ADDR_SCRATCH_A, v);
      rd_chk("scratch_b", SMCR_ADDR_SCRATCH_B, ~v);
    end
    $display("scratch done");
    repeat (8)
    begin
      v = 16'($urandom);
      wr_reg(SMCR_ADDR_WAKE_ID, v);
      chk("pull_req", {8'h00, v[7:0]}, {8'h00, p2, p3});
      chk("id_cfg", {9'h000, v[14:8]}, {9'h000, cfg});
      rd_chk("wake_id", SMCR_ADDR_WAKE_ID, {1'b0, v[14:8], 8'h00});
    end
    $display("wake id done");
    // Every state code; all-ones write also hits the read-only field
    for (int s = 0; s < 8; s++)
    begin
      @(posedge sys_clk);
      xs <= s[2:0];
      v = (s == 7) ? 16'hFFFF : 16'($urandom);
      repeat (4) @(posedge sys_clk);
      wr_reg(SMCR_ADDR_MASK_STATE, v);
      rd_chk("mask_state", SMCR_ADDR_MASK_STATE, {11'h000, s[2:0], v[1:0]});
    end
    $display("mask state done");
    for (int b = 0; b < 2; b++)
    begin
      wr_reg(SMCR_ADDR_MASK_STATE, 16'h0000);
      @(posedge sys_clk);
      st[b] <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1 chk("irq", 16'h0001, {15'h0000, irq});
      rd_chk("events", SMCR_ADDR_EVENTS, 16'h0001 << b);
      wr_reg(SMCR_ADDR_MASK_STATE, 16'h0001 << b);
      @(posedge sys_clk);
      #1 chk("irq_masked", 16'h0000, {15'h0000, irq});
      wr_reg(SMCR_ADDR_EVENTS, 16'h0001 << b);
      @(posedge sys_clk);
      st[b] <= 1'b0;
      wr_reg(SMCR_ADDR_MASK_STATE, 16'h0000);
      rd_chk("cleared", SMCR_ADDR_EVENTS, 16'h0000);
      chk("irq_clear", 16'h0000, {15'h0000, irq});
    end
    $display("events done");
    wr_reg(4'hF, 16'hFFFF);
    rd_chk("unmapped", 4'hF, 16'h0000);
    wr_reg(SMCR_ADDR_WAKE_ID, 16'h7F00);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd_chk("scratch_por", SMCR_ADDR_SCRATCH_A, 16'h0000);
    rd_chk("wake_id_por", SMCR_ADDR_WAKE_ID, 16'h0000);
    chk("id_cfg_por", 16'h0000, {9'h000, cfg});
    rd_chk("mask_por", SMCR_ADDR_MASK_STATE, 16'h001C);
    $display("reset done");
    complete_run;
  end
endmodule // tb_smcr_misc_regs
